//--- hdl/mdaf_map.vh
`ifndef MDAF_MAP_VH
`define MDAF_MAP_VH
// register indices (byte address = index * 4)
`define MDAF_IDX_TXDEV 8'h0e
`define MDAF_IDX_FCTL 8'h0f
`define MDAF_IDX_FILT 8'h10
`define MDAF_IDX_STAT 8'h11
`define MDAF_ADDR_W 8
// reset values
`define MDAF_RST_TXDEV 8'he8
`define MDAF_RST_FCTL 8'h9c
`define MDAF_RST_FILT 8'h00
// field positions
`define MDAF_TX_SHAPING 7
`define MDAF_TXX_HI 6
`define MDAF_TXX_LO 4
`define MDAF_TXM_HI 3
`define MDAF_TXM_LO 0
`define MDAF_SETTLE_HI 7
`define MDAF_SETTLE_LO 6
`define MDAF_RXX_HI 5
`define MDAF_RXX_LO 4
`define MDAF_RXM_HI 3
`define MDAF_RXM_LO 0
`define MDAF_BYPASS 7
`define MDAF_SHIFT_HI 6
`define MDAF_SHIFT_LO 5
`define MDAF_DIV_HI 4
`define MDAF_DIV_LO 0
// deviation exponent offsets: tx per band, plus the rx offset
`define MDAF_TX_EXP_LO_BAND 5'h10
`define MDAF_TX_EXP_HI_BAND 5'h0f
`define MDAF_RX_EXP_OFS 3'h3
`endif

//--- hdl/mdaf_decim_div.v
`timescale 1ns/1ps
`include "mdaf_map.vh"
// decimation clock enable: one pulse every (divisor field + 1) cycles
module mdaf_decim_div (
   input wire core_clk,
   input wire reset,
   input wire [4:0] div_field,
   output reg tick_r
);
   reg [4:0] cnt_r;
   always @(posedge core_clk) begin
      if (reset) begin
         cnt_r <= 5'h00;
         tick_r <= 1'b0;
      end else if (cnt_r >= div_field) begin
         cnt_r <= 5'h00;
         tick_r <= 1'b1;
      end else begin
         cnt_r <= cnt_r + 5'h01;
         tick_r <= 1'b0;
      end
   end
endmodule

//--- hdl/mdaf_regs.v
`timescale 1ns/1ps
`include "mdaf_map.vh"
// Functional notes
// - deviation bit 7 enables gaussian tx shaping, resets to 1.
// - tx exponent bits 6:4 reset 6, mantissa bits 3:0 reset 8.
// - lower band deviation is fref times mantissa times 2^(exp-16).
// - upper band deviation is fref times mantissa times 2^(exp-15).
// - tx mantissa zero selects on-off keying for rx and tx.
// - settling bits 7:6 reset 2; 0 off, else 1,2,4 bit pairs.
// - rx exponent resets 1, mantissa 12; deviation baud*m*2^(x-3)/3.
// - filter bit 7 resets 0 and bypasses analog anti-alias filter.
// - filter bits 6:5 give decimator input extra shift, reset 0.
// - 5-bit decimation field gives divisor of field plus one.
// - channel bandwidth is base bandwidth over decimation divisor.
module mdaf_regs (
   input wire core_clk,
   input wire reset,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [9:0] wb_adr_i,
   input wire [31:0] wb_dat_i,
   input wire [3:0] wb_sel_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   output reg wb_err_o,
   output reg tx_shaping_r,
   output reg [2:0] tx_dev_exponent_r,
   output reg [3:0] tx_dev_mantissa_r,
   output reg ook_mode_r,
   output reg [4:0] tx_dev_shift_lo_r,
   output reg [4:0] tx_dev_shift_hi_r,
   output reg afc_enable_r,
   output reg [2:0] afc_avg_pairs_r,
   output reg [1:0] rx_dev_exponent_r,
   output reg [3:0] rx_dev_mantissa_r,
   output reg [6:0] rx_dev_scaled_r,
   output reg filter_bypass_r,
   output reg [1:0] decim_input_shift_r,
   output reg [4:0] decim_clk_divisor_r,
   output reg [5:0] decim_divisor_r,
   output reg decim_tick_r
);
   ////////////////////////////////////////////////////////////////////////
   reg [7:0] txdev_r;
   reg [7:0] fctl_r;
   reg [7:0] filt_r;
   reg [7:0] busy_cnt_r;
   wire [7:0] idx;
   wire req;
   wire wr_lane;
   wire hit;
   wire tick;
   reg [7:0] rd_nxt;
   assign idx = wb_adr_i[9:2];
   assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
   assign wr_lane = wb_we_i & wb_sel_i[0];
   assign hit = (idx == `MDAF_IDX_TXDEV) | (idx == `MDAF_IDX_FCTL) |
                (idx == `MDAF_IDX_FILT) | (idx == `MDAF_IDX_STAT);

   always @* begin
      case (idx)
         `MDAF_IDX_TXDEV: rd_nxt = txdev_r;
         `MDAF_IDX_FCTL: rd_nxt = fctl_r;
         `MDAF_IDX_FILT: rd_nxt = filt_r;
         `MDAF_IDX_STAT: rd_nxt = busy_cnt_r;
         default: rd_nxt = 8'h00;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // bus slave: ack one cycle after request, err on unmapped index
   always @(posedge core_clk) begin
      if (reset) begin
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
         txdev_r <= `MDAF_RST_TXDEV;
         fctl_r <= `MDAF_RST_FCTL;
         filt_r <= `MDAF_RST_FILT;
      end else begin
         wb_ack_o <= req & hit;
         wb_err_o <= req & ~hit;
         wb_dat_o <= (req & hit) ? {24'h000000, rd_nxt} : 32'h00000000;
         if (req & wr_lane) begin
            case (idx)
               `MDAF_IDX_TXDEV: txdev_r <= wb_dat_i[7:0];
               `MDAF_IDX_FCTL: fctl_r <= wb_dat_i[7:0];
               `MDAF_IDX_FILT: filt_r <= wb_dat_i[7:0];
               default: txdev_r <= txdev_r;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // modem-facing settings follow the stored registers one cycle later,
   // so they change only after the write has been acknowledged
   always @(posedge core_clk) begin
      if (reset) begin
         tx_shaping_r <= 1'b1;
         tx_dev_exponent_r <= 3'h6;
         tx_dev_mantissa_r <= 4'h8;
         ook_mode_r <= 1'b0;
         tx_dev_shift_lo_r <= 5'h0a;
         tx_dev_shift_hi_r <= 5'h09;
         afc_enable_r <= 1'b1;
         afc_avg_pairs_r <= 3'h2;
         rx_dev_exponent_r <= 2'h1;
         rx_dev_mantissa_r <= 4'hc;
         // reset mantissa 12 shifted by reset exponent 1, so no step after release
         rx_dev_scaled_r <= 7'h18;
         filter_bypass_r <= 1'b0;
         decim_input_shift_r <= 2'h0;
         decim_clk_divisor_r <= 5'h00;
         decim_divisor_r <= 6'h01;
         decim_tick_r <= 1'b0;
         busy_cnt_r <= 8'h00;
      end else begin
         tx_shaping_r <= txdev_r[`MDAF_TX_SHAPING];
         tx_dev_exponent_r <= txdev_r[`MDAF_TXX_HI:`MDAF_TXX_LO];
         tx_dev_mantissa_r <= txdev_r[`MDAF_TXM_HI:`MDAF_TXM_LO];
         ook_mode_r <= (txdev_r[`MDAF_TXM_HI:`MDAF_TXM_LO] == 4'h0);
         // right shift of fref*mantissa: deviation = fref*m >> (offset - exp)
         tx_dev_shift_lo_r <= `MDAF_TX_EXP_LO_BAND - {2'b00, txdev_r[`MDAF_TXX_HI:`MDAF_TXX_LO]};
         tx_dev_shift_hi_r <= `MDAF_TX_EXP_HI_BAND - {2'b00, txdev_r[`MDAF_TXX_HI:`MDAF_TXX_LO]};
         afc_enable_r <= (fctl_r[`MDAF_SETTLE_HI:`MDAF_SETTLE_LO] != 2'h0);
         case (fctl_r[`MDAF_SETTLE_HI:`MDAF_SETTLE_LO])
            2'h1: afc_avg_pairs_r <= 3'h1;
            2'h2: afc_avg_pairs_r <= 3'h2;
            2'h3: afc_avg_pairs_r <= 3'h4;
            default: afc_avg_pairs_r <= 3'h0;
         endcase
         rx_dev_exponent_r <= fctl_r[`MDAF_RXX_HI:`MDAF_RXX_LO];
         rx_dev_mantissa_r <= fctl_r[`MDAF_RXM_HI:`MDAF_RXM_LO];
         // m * 2^x in units of baud/24 (2^-3 and /3 folded in)
         rx_dev_scaled_r <= {3'b000, fctl_r[`MDAF_RXM_HI:`MDAF_RXM_LO]} << fctl_r[`MDAF_RXX_HI:`MDAF_RXX_LO];
         filter_bypass_r <= filt_r[`MDAF_BYPASS];
         decim_input_shift_r <= filt_r[`MDAF_SHIFT_HI:`MDAF_SHIFT_LO];
         decim_clk_divisor_r <= filt_r[`MDAF_DIV_HI:`MDAF_DIV_LO];
         // bandwidth = 307.2 kHz / this divisor
         decim_divisor_r <= {1'b0, filt_r[`MDAF_DIV_HI:`MDAF_DIV_LO]} + 6'h01;
         decim_tick_r <= tick;
         if (tick)
            busy_cnt_r <= busy_cnt_r + 8'h01;
      end
   end

   mdaf_decim_div u_div (
      .core_clk(core_clk),
      .reset(reset),
      .div_field(decim_clk_divisor_r),
      .tick_r(tick)
   );
endmodule

//--- tb/mdaf_regs_assertions.sv
`timescale 1ns/1ps
module mdaf_regs_assertions (
   input wire core_clk, reset, wb_cyc_i, wb_stb_i, wb_ack_o, wb_err_o, ook_mode_r, afc_enable_r, decim_tick_r,
   input wire [9:0] wb_adr_i,
   input wire [31:0] wb_dat_o,
   input wire [3:0] tx_dev_mantissa_r,
   input wire [2:0] tx_dev_exponent_r, afc_avg_pairs_r,
   input wire [4:0] tx_dev_shift_lo_r, tx_dev_shift_hi_r, decim_clk_divisor_r,
   input wire [5:0] decim_divisor_r
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   wire hit = wb_adr_i[9:2] >= 8'h0e && wb_adr_i[9:2] <= 8'h11;
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   endsequence
   // divisor 32 held: no second tick inside the gap
   sequence s_gap;
      (!decim_tick_r && decim_divisor_r == 6'h20)[*8];
   endsequence
   a_ack_mapped: assert property (s_req ##0 hit |=> wb_ack_o && !wb_err_o) else $error("no ack");
   a_err_unmapped: assert property (s_req ##0 !hit |=> wb_err_o && !wb_ack_o) else $error("no err");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
   a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data idle");
   a_ook_mant: assert property (ook_mode_r == (tx_dev_mantissa_r == 4'h0)) else $error("keying");
   a_band_shift: assert property (tx_dev_shift_lo_r == 5'h10 - tx_dev_exponent_r
      && tx_dev_shift_hi_r == 5'h0f - tx_dev_exponent_r) else $error("shift");
   a_afc_pairs: assert property (afc_enable_r == (afc_avg_pairs_r != 3'h0)
      && afc_avg_pairs_r != 3'h3) else $error("pairs");
   a_div_plus: assert property (decim_divisor_r == {1'h0, decim_clk_divisor_r} + 6'h01) else $error("div");
   a_tick_gap: assert property (decim_tick_r && decim_divisor_r == 6'h20 && $stable(decim_divisor_r)
      |=> s_gap) else $error("tick gap");
endmodule
bind mdaf_regs mdaf_regs_assertions chk (.*);

//--- tb/tb_mdaf_regs.sv
`timescale 1ns/1ps
module tb_mdaf_regs;
   reg core_clk = 1'h0, reset = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
   reg [9:0] wb_adr_i = 10'h0;
   reg [31:0] wb_dat_i = 32'h0;
   reg [3:0] wb_sel_i = 4'hf;
   wire [31:0] wb_dat_o;
   wire wb_ack_o, wb_err_o, tx_shaping_r, ook_mode_r, afc_enable_r, filter_bypass_r, decim_tick_r;
   wire [2:0] tx_dev_exponent_r, afc_avg_pairs_r;
   wire [3:0] tx_dev_mantissa_r, rx_dev_mantissa_r;
   wire [4:0] tx_dev_shift_lo_r, tx_dev_shift_hi_r, decim_clk_divisor_r;
   wire [1:0] rx_dev_exponent_r, decim_input_shift_r;
   wire [6:0] rx_dev_scaled_r;
   wire [5:0] decim_divisor_r;
   integer mismatches = 0, samples_checked = 0, i, n;
   reg [31:0] got;
   reg gerr;
   reg [7:0] v;
   mdaf_regs uut (.*);
   initial forever #10 core_clk = ~core_clk;
   ////////////////////////////////////////////////////////////////////////
   task wrap_up;
      begin
         $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
         if (mismatches == 0 && samples_checked > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask
   task cmp(input [31:0] g, input [31:0] e);
      begin
         samples_checked = samples_checked + 1;
         if (g !== e) begin
            mismatches = mismatches + 1;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
         end
      end
   endtask
   // holds the request until ack or err is sampled, then one idle cycle
   task wb(input w, input [9:0] a, input [31:0] d);
      integer k;
      begin
         wb_cyc_i <= 1'h1;
         wb_stb_i <= 1'h1;
         wb_we_i <= w;
         wb_adr_i <= a;
         wb_dat_i <= d;
         k = 0;
         @(posedge core_clk);
         while (!(wb_ack_o | wb_err_o) && k < 20) begin
            @(posedge core_clk);
            k = k + 1;
         end
         if (k == 20) begin
            mismatches = mismatches + 1;
            $display("mismatch at %0t: no answer", $time);
         end
         got = wb_dat_o;
         gerr = wb_err_o;
         wb_cyc_i <= 1'h0;
         wb_stb_i <= 1'h0;
         wb_we_i <= 1'h0;
         @(posedge core_clk);
      end
   endtask
   task wr(input [7:0] d, input [9:0] a);
      begin
         wb(1'h1, a, {24'h0, d});
         wb(1'h0, a, 32'h0);
         cmp(got, {24'h0, d});
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (6) @(posedge core_clk);
      reset <= 1'h0;
      @(posedge core_clk);
      for (i = 0; i < 3; i = i + 1) begin
         wb(1'h0, 10'(10'h38 + 4 * i), 32'h0);
         cmp(got, i == 0 ? 32'he8 : i == 1 ? 32'h9c : 32'h0);
      end
      for (i = 0; i < 2; i = i + 1) begin
         v = i ? 8'h7f : 8'h00;
         wr(v, 10'h38);
         cmp({tx_shaping_r, tx_dev_exponent_r, tx_dev_mantissa_r, ook_mode_r}, {v, v[3:0] == 4'h0});
         cmp({tx_dev_shift_lo_r, tx_dev_shift_hi_r}, {5'h10 - v[6:4], 5'h0f - v[6:4]});
      end
      for (i = 0; i < 4; i = i + 1) begin
         v = {i[1:0], 6'h29};
         wr(v, 10'h3c);
         cmp({afc_enable_r, afc_avg_pairs_r, rx_dev_exponent_r, rx_dev_mantissa_r, rx_dev_scaled_r},
            {i != 0, i == 0 ? 3'h0 : 3'h1 << (i - 1), 2'h2, 4'h9, 7'h24});
      end
      wr(8'hdf, 10'h40);
      cmp({filter_bypass_r, decim_input_shift_r, decim_clk_divisor_r, decim_divisor_r}, 14'h37e0);
      n = 0;
      repeat (320) begin
         @(posedge core_clk);
         n = n + decim_tick_r;
      end
      cmp(n, 32'ha);
      // byte lane 0 off: write is answered but must not land
      wb_sel_i <= 4'he;
      wb(1'h1, 10'h40, 32'h0);
      wb_sel_i <= 4'hf;
      wb(1'h0, 10'h40, 32'h0);
      cmp(got, 32'hdf);
      wb(1'h1, 10'h48, 32'h0);
      cmp(gerr, 32'h1);
      wb(1'h1, 10'h44, 32'h0);
      cmp(gerr, 32'h0);
      wrap_up;
   end
   initial begin
      #100000;
      mismatches = mismatches + 1;
      wrap_up;
   end
endmodule
